// File: rtl/nsm_consts.svh
/*
  Offsets, field positions and timing counts of the nibble multiplier.
  Assumes inclusion by bare name from rtl/ sources.
*/
`ifndef NSM_CONSTS_SVH
`define NSM_CONSTS_SVH

// Register offsets on the special-function register port
`define NSM_ADDR_A_LOW   8'h0E
`define NSM_ADDR_A_MID   8'h0F
`define NSM_ADDR_A_HIGH  8'h10
`define NSM_ADDR_B_LOW   8'h11
`define NSM_ADDR_B_HIGH  8'h12

// Widths of operands and product
`define NSM_A_W          12
`define NSM_B_W          8
`define NSM_P_W          20
`define NSM_NIB_W        4
`define NSM_NUM_REGS     5

// Cycles from starting write to product ready
`define NSM_MUL_CYCLES   1

`endif

// File: rtl/nsm_mul_core.sv
/*
  Combinational signed-by-unsigned multiply core.
  Assumes operands are stable while its result is sampled.
*/
`timescale 1ns/1ps
`default_nettype none
`include "nsm_consts.svh"

module nsm_mul_core #(
  parameter int A_W = `NSM_A_W,
  parameter int B_W = `NSM_B_W
) (
  input  wire logic [A_W-1:0]     signed_operand_bits,
  input  wire logic [B_W-1:0]     unsigned_operand_bits,
  output logic      [A_W+B_W-1:0] product_bits
);

  wire logic signed [A_W+B_W-1:0] a_ext;
  wire logic signed [A_W+B_W-1:0] b_ext;
  wire logic signed [A_W+B_W-1:0] prod_full;

  // Sign-extend A, zero-extend B, then multiply at full width
  assign a_ext = {{B_W{signed_operand_bits[A_W-1]}}, signed_operand_bits};
  assign b_ext = {{A_W{1'b0}}, unsigned_operand_bits};
  assign prod_full = a_ext * b_ext;
  assign product_bits = prod_full;

endmodule // nsm_mul_core
`default_nettype wire

// File: rtl/nsm_multiplier.sv
/*
  Five-nibble special-function-register multiplier: 12-bit signed times
  8-bit unsigned giving a 20-bit signed product read back nibble-wise.
  Assumes the core drives one register access per clock with address,
  write strobe, write data and read strobe on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "nsm_consts.svh"

// Functional notes
// - The product is the 12-bit signed A times 8-bit unsigned B, 20 bits.
// - A is written as nibbles at 0EH, 0FH and 10H, low to high.
// - B is written as nibbles at 11H (low) and 12H (high).
// - Reads of 0EH..12H return product nibbles 0 through 4 in order.
// - Writing B's high nibble starts the multiply with no other command.
// - The product overwrites the operands, so software rewrites them all.
// - Five shared four-bit registers exist, undefined after reset.
module nsm_multiplier #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic [3:0]        sfr_wdata,
  input  wire logic              sfr_rd,
  output logic      [3:0]        sfr_rdata,
  output logic                   sfr_hit,
  output logic                   busy
);

  // Widths of the shared nibble map
  localparam int NIB_W  = `NSM_NIB_W;
  localparam int N_REGS = `NSM_NUM_REGS;
  localparam int P_W    = `NSM_P_W;

  // Elaboration checks: five address bits are needed to reach the map,
  // the product must split evenly over the shared nibbles, and the A and B widths must add up to it
  if (ADDR_W < 5) begin : g_chk_addr
    $error("ADDR_W too small for register map");
  end
  if (N_REGS * NIB_W != P_W) begin : g_chk_nib
    $error("Product does not fill the nibble registers");
  end
  if (`NSM_A_W + `NSM_B_W != P_W) begin : g_chk_prod
    $error("Operand widths do not add up to the product width");
  end

  // Shared nibble storage: operand on write, product after a multiply
  nsm_pkg::nsm_nib_t   regs_q [N_REGS];
  nsm_pkg::nsm_state_e state_q;
  nsm_pkg::nsm_state_e state_d;
  logic [3:0]          rdata_q;

  wire logic [N_REGS-1:0]   sel;
  wire logic [N_REGS-1:0]   wr_en;          // Per-nibble write enables
  wire logic                start;
  wire logic                calc;           // Product lands this cycle
  wire logic [`NSM_A_W-1:0] op_a;
  wire logic [`NSM_B_W-1:0] op_b;
  wire nsm_pkg::nsm_prod_t  prod;
  wire nsm_pkg::nsm_nib_t   rd_val [N_REGS];   // Value a read would see
  wire nsm_pkg::nsm_nib_t   rd_sel [N_REGS];   // Masked by its select
  wire nsm_pkg::nsm_nib_t   rd_or  [N_REGS+1]; // OR chain of selections
  wire nsm_pkg::nsm_nib_t   rdata_d;

  // Address decode, one select per register
  assign sel[0] = (sfr_addr == ADDR_W'(`NSM_ADDR_A_LOW));
  assign sel[1] = (sfr_addr == ADDR_W'(`NSM_ADDR_A_MID));
  assign sel[2] = (sfr_addr == ADDR_W'(`NSM_ADDR_A_HIGH));
  assign sel[3] = (sfr_addr == ADDR_W'(`NSM_ADDR_B_LOW));
  assign sel[4] = (sfr_addr == ADDR_W'(`NSM_ADDR_B_HIGH));
  assign sfr_hit = |sel;
  assign start = sfr_wr & sel[4];

  // Operand assembly from the nibble registers
  assign op_a = {regs_q[2], regs_q[1], regs_q[0]};
  assign op_b = {regs_q[4], regs_q[3]};
  assign calc = (state_q == nsm_pkg::NSM_CALC);
  assign busy = calc;

  nsm_mul_core #(
    .A_W(`NSM_A_W),
    .B_W(`NSM_B_W)
  ) u_core (
    .signed_operand_bits  (op_a),
    .unsigned_operand_bits(op_b),
    .product_bits         (prod)
  );

  // Sequencer: one calculation cycle after the starting write
  always_comb begin
    case (state_q)
      nsm_pkg::NSM_IDLE: state_d = start ? nsm_pkg::NSM_CALC
                                          : nsm_pkg::NSM_IDLE;
      nsm_pkg::NSM_CALC: state_d = nsm_pkg::NSM_IDLE;
      default:           state_d = nsm_pkg::NSM_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= nsm_pkg::NSM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Unmapped reads fall through the OR chain as zero
  assign rd_or[0] = 4'h0;

  // Per nibble: write enable, read value and storage
  for (genvar i = 0; i < N_REGS; i++) begin : g_nib
    // Writes in the calc cycle lose to the product
    assign wr_en[i] = sfr_wr & sel[i] & ~calc;
    // A read in the calc cycle already sees the product
    assign rd_val[i] = calc ? prod[i*NIB_W +: NIB_W] : regs_q[i];
    assign rd_sel[i] = sel[i] ? rd_val[i] : 4'h0;
    assign rd_or[i+1] = rd_or[i] | rd_sel[i];

    // Product overwrites the operand nibble in the calc cycle
    always_ff @(posedge clk) begin
      if (calc) begin
        regs_q[i] <= prod[i*NIB_W +: NIB_W];
      end else if (wr_en[i]) begin
        regs_q[i] <= sfr_wdata;
      end
    end
  end

  // Selected nibble; selects are one-hot so the OR is a mux
  assign rdata_d = rd_or[N_REGS];

  // Registered read data, held until the next read strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 4'h0;
    end else if (sfr_rd) begin
      rdata_q <= rdata_d;
    end
  end
  assign sfr_rdata = rdata_q;

endmodule // nsm_multiplier
`default_nettype wire

// File: rtl/nsm_pkg.sv
/*
  Types shared by the nibble multiplier files.
  Assumes nsm_consts.svh is reachable on the include path.
*/
`include "nsm_consts.svh"

package nsm_pkg;
  typedef logic [`NSM_NIB_W-1:0] nsm_nib_t;
  typedef logic [`NSM_P_W-1:0]   nsm_prod_t;
  typedef enum logic {
    NSM_IDLE,
    NSM_CALC
  } nsm_state_e;
endpackage

// File: verification/nsm_multiplier_chk.sv
/* Port checker for nsm_multiplier.
   Assumes it is bound into every nsm_multiplier instance. */
`timescale 1ns/1ps
`default_nettype none
module nsm_chk #(parameter int ADDR_W = 8) (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic [ADDR_W-1:0] sfr_addr,
  input wire logic              sfr_wr,
  input wire logic [3:0]        sfr_wdata,
  input wire logic              sfr_rd,
  input wire logic [3:0]        sfr_rdata,
  input wire logic              sfr_hit,
  input wire logic              busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Write of the high nibble of B
  wire start_wr = sfr_wr && sfr_addr == 8'h12;
  // Status, decode and read-back timing
  hit_decode_a: assert property
    (sfr_hit == (sfr_addr >= 8'h0E && sfr_addr <= 8'h12)) else $error("hit");
  busy_start_a: assert property (start_wr |=> busy) else $error("start");
  busy_cause_a: assert property (busy |-> $past(start_wr))
    else $error("stray busy");
  busy_pulse_a: assert property (busy |=> !busy) else $error("busy");
  rd_hold_a: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
    else $error("rdata moved");
  unmapped_rd_a: assert property
    (sfr_rd && !sfr_hit |=> sfr_rdata == 4'h0) else $error("unmapped");
  rst_busy_a: assert property ($fell(srst) |-> !busy) else $error("rst");
  rst_rdata_a: assert property
    ($fell(srst) |-> sfr_rdata == 4'h0) else $error("rst rdata");
  cover property (start_wr ##3 sfr_rd && sfr_hit);
  cover property (sfr_rd && !sfr_hit);
  cover property (busy);
  cover property (busy && sfr_rd && sfr_hit);
endmodule // nsm_chk
bind nsm_multiplier nsm_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .srst(srst),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .busy(busy));
`default_nettype wire

// File: verification/nsm_multiplier_tb.sv
/* Self-checking bench for nsm_multiplier.
   Assumes the design and its checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  n_mismatch++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module nibble_signed_unsigned_multiplier_tb_top;
  logic       clk = 1'b0, srst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [3:0] sfr_wdata = 4'h0;
  wire  [3:0] sfr_rdata;
  wire        sfr_hit, busy;
  int         n_mismatch = 0, total_checks = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  nsm_multiplier uut (.clk(clk), .srst(srst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .busy(busy));
  // One write strobe, launched off the falling edge
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  // One read strobe, data checked a cycle later
  task automatic rd(input logic [7:0] a, input logic [3:0] e);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    `CHK("rdata", e, sfr_rdata)
  endtask
  // Full operand load, start, then product read-back
  task automatic mul(input logic [11:0] a, input logic [7:0] b);
    logic [19:0] p;
    p = $signed(a) * $signed({1'b0, b});
    wr(8'h0E, a[3:0]);
    wr(8'h0F, a[7:4]);
    wr(8'h10, a[11:8]);
    wr(8'h11, b[3:0]);
    wr(8'h12, b[7:4]);
    `CHK("busy", 1'b1, busy)
    @(negedge clk);
    `CHK("busy", 1'b0, busy)
    for (int i = 0; i < 5; i++) rd(8'h0E + 8'(i), p[4*i +: 4]);
  endtask
  // Starting write, then a read in the very next cycle
  task automatic mul_fast(input logic [11:0] a, input logic [7:0] b);
    logic [19:0] p;
    p = $signed(a) * $signed({1'b0, b});
    wr(8'h0E, a[3:0]);
    wr(8'h0F, a[7:4]);
    wr(8'h10, a[11:8]);
    wr(8'h11, b[3:0]);
    @(negedge clk);
    sfr_addr = 8'h12;
    sfr_wdata = b[7:4];
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_addr = 8'h0E;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    `CHK("rdata_fast", p[3:0], sfr_rdata)
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Reset, unmapped access, then signed corner products
  initial begin
    repeat (5) @(negedge clk);
    srst = 1'b0;
    wr(8'h13, 4'hF);
    rd(8'h13, 4'h0);
    mul(12'h7FF, 8'hFF);
    mul(12'h800, 8'hFF);
    mul(12'hFFF, 8'h01);
    mul(12'h5A3, 8'h00);
    mul_fast(12'h9C4, 8'hB7);
    final_report();
  end
endmodule // nibble_signed_unsigned_multiplier_tb_top
`default_nettype wire
